/* File: design/scc_pkg.sv */
/*
 System clock control package: register map, field positions, reset
 values, timing counts and the carrier types of the clock control block.
 Assumes a 100 MHz bus clock that runs at twice the master clock rate.
*/
package scc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] PRESCALE_IDX = 10'h061;
    localparam logic [9:0] TRIM_IDX = 10'h062;
    localparam logic [9:0] CTRL_IDX = 10'h063;
    localparam logic [9:0] STATUS_IDX = 10'h064;

    localparam int PCE_BIT = 7;
    localparam logic [7:0] PCE_UNLOCK = 8'h80;
    localparam logic [3:0] SEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] SEL_RST_DIV8 = 4'h3;
    localparam logic [3:0] SEL_MAX = 4'h8;
    localparam logic [2:0] PCE_WINDOW = 3'h4;
    localparam logic [3:0] EXT_CLK_CODE = 4'h0;
    localparam logic [3:0] RC_CLK_CODE = 4'h2;
    localparam int CTRL_TMR_EXT_BIT = 0;

    localparam logic [1:0] SUT_BASE = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ACLK_PER_CK = 2;
    localparam int RESET_BASE_CK = 14;
    localparam int WAKE_CK = 6;
    localparam int SHORT_DELAY_NS = 4100000;
    localparam int LONG_DELAY_NS = 65000000;
    localparam int SHORT_DELAY_CYCLES =
        (SHORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_DELAY_CYCLES =
        (LONG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_BASE_CYCLES = RESET_BASE_CK * ACLK_PER_CK;
    localparam int WAKE_CYCLES = WAKE_CK * ACLK_PER_CK;

    typedef struct packed {
        logic [3:0] src;
        logic [1:0] startup_time_fuses;
        logic clock_output_fuse;
        logic div8;
    } scc_fuse_type;

    typedef struct packed {
        logic io;
        logic converter;
        logic core;
        logic program_memory;
    } scc_domain_type;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } scc_phase_type;

    typedef struct packed {
        scc_fuse_type fuse_s1;
        scc_fuse_type fuse_s2;
        scc_fuse_type fuse_lat;
        logic [7:0] trim_s1;
        logic [7:0] trim_s2;
        logic pd_s1;
        logic pd_s2;
        logic [3:0] sel;
        logic [3:0] act_sel;
        logic pend;
        logic pce;
        logic [2:0] pce_cnt;
        logic [7:0] trim;
        logic tmr_ext;
        logic [7:0] half_cnt;
        logic clk_div;
        logic tick;
        logic [23:0] dly;
        scc_phase_type phase;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } scc_state_type;

endpackage : scc_pkg

/* File: design/scc_top.sv */
/*
 System clock control: prescaled system clock generation, unlock-guarded
 prescaler register, RC trim register, start-up and wake delays, clock
 output pin, all behind an AXI4-Lite slave.
 Assumes aclk runs at twice the master clock; one master CK is two aclk
 cycles. Fuse, trim and power-down inputs are asynchronous pins.
*/
`timescale 1ns/100ps
module scc_top #(
    parameter int ADDR_W = 12,
    parameter logic [23:0] SHORT_DELAY_CYCLES =
        24'(scc_pkg::SHORT_DELAY_CYCLES),
    parameter logic [23:0] LONG_DELAY_CYCLES =
        24'(scc_pkg::LONG_DELAY_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire scc_pkg::scc_fuse_type fuses,
    input wire logic [7:0] factory_trim,
    input wire logic power_down,
    output logic clock_output_pin,
    output logic clock_output_pin_oe,
    output scc_pkg::scc_domain_type domain_en,
    output logic [7:0] rc_oscillator_trim_out,
    output logic ext_clock_selected,
    output logic timer_osc_enable,
    output logic timer_external_clock_select,
    output logic core_running
);

    localparam logic [ADDR_W-1:0] PRESCALE_ADDR =
        ADDR_W'({scc_pkg::PRESCALE_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] TRIM_ADDR =
        ADDR_W'({scc_pkg::TRIM_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] CTRL_ADDR =
        ADDR_W'({scc_pkg::CTRL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] STATUS_ADDR =
        ADDR_W'({scc_pkg::STATUS_IDX, 2'b00});

    scc_pkg::scc_state_type s_ff;
    scc_pkg::scc_state_type nxt_s;
    logic wr_take;
    logic rd_take;
    logic [2:0] wr_hit;
    logic [7:0] wd;

    // Register decode: 0 unmapped, 1 prescale, 2 trim, 3 control, 4 status
    function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        if (w == PRESCALE_ADDR)
            reg_hit = 3'h1;
        else if (w == TRIM_ADDR)
            reg_hit = 3'h2;
        else if (w == CTRL_ADDR)
            reg_hit = 3'h3;
        else if (w == STATUS_ADDR)
            reg_hit = 3'h4;
        else
            reg_hit = 3'h0;
    endfunction : reg_hit

    // factor is two to the select code
    // Half period of the divided clock, in aclk cycles, minus one
    function automatic logic [7:0] half_limit(input logic [3:0] sel);
        half_limit = 8'((9'h001 << sel) - 9'h001);
    endfunction : half_limit

    function automatic logic [23:0] boot_delay(input logic [1:0] startup_time_fuses);
        logic [23:0] base;
        base = 24'(scc_pkg::RESET_BASE_CYCLES);
        if (startup_time_fuses == scc_pkg::SUT_BASE)
            boot_delay = base - 24'h000001;
        else if (startup_time_fuses == scc_pkg::SUT_SHORT)
            boot_delay = base + SHORT_DELAY_CYCLES - 24'h000001;
        else
            boot_delay = base + LONG_DELAY_CYCLES - 24'h000001;
    endfunction : boot_delay

    assign s_axi_awready = ce && s_axi_awvalid && s_axi_wvalid && !s_ff.bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ce && !s_ff.rvalid;
    assign wr_take = s_axi_awready;
    assign rd_take = s_axi_arready && s_axi_arvalid;
    assign wr_hit = reg_hit(s_axi_awaddr);
    assign wd = s_axi_wdata[7:0];

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.fuse_s1 = fuses;
        nxt_s.fuse_s2 = s_ff.fuse_s1;
        nxt_s.trim_s1 = factory_trim;
        nxt_s.trim_s2 = s_ff.trim_s1;
        nxt_s.pd_s1 = power_down;
        nxt_s.pd_s2 = s_ff.pd_s1;
        nxt_s.tick = 1'b0;
        if (!aresetn)
        begin
            // Output clock keeps toggling through reset; if() also
            // recovers from an unknown start value in simulation
            if (s_ff.clk_div)
                nxt_s.clk_div = 1'b0;
            else
                nxt_s.clk_div = 1'b1;
            nxt_s.half_cnt = 8'h00;
            nxt_s.fuse_lat = s_ff.fuse_s2;
            nxt_s.sel = s_ff.fuse_s2.div8 ? scc_pkg::SEL_RST_DIV8
                                          : scc_pkg::SEL_RST_PLAIN;
            nxt_s.act_sel = nxt_s.sel;
            nxt_s.pend = 1'b0;
            nxt_s.pce = 1'b0;
            nxt_s.pce_cnt = 3'h0;
            nxt_s.trim = s_ff.trim_s2;
            nxt_s.tmr_ext = 1'b0;
            nxt_s.dly = boot_delay(s_ff.fuse_s2.startup_time_fuses);
            nxt_s.phase = scc_pkg::ST_BOOT;
            nxt_s.bvalid = 1'b0;
            nxt_s.bresp = scc_pkg::RESP_OKAY;
            nxt_s.rvalid = 1'b0;
            nxt_s.rresp = scc_pkg::RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
        end
        else
        begin
            if (s_ff.half_cnt == half_limit(s_ff.act_sel))
            begin
                nxt_s.half_cnt = 8'h00;
                nxt_s.clk_div = !s_ff.clk_div;
                if (!s_ff.clk_div)
                begin
                    nxt_s.tick = s_ff.phase == scc_pkg::ST_RUN;
                    if (s_ff.pend)
                    begin
                        nxt_s.act_sel = s_ff.sel;
                        nxt_s.pend = 1'b0;
                    end
                end
            end
            else
                nxt_s.half_cnt = s_ff.half_cnt + 8'h01;

            case (s_ff.phase)
                scc_pkg::ST_BOOT:
                    if (s_ff.dly == 24'h000000)
                        nxt_s.phase = scc_pkg::ST_RUN;
                    else
                        nxt_s.dly = s_ff.dly - 24'h000001;
                scc_pkg::ST_RUN:
                    if (s_ff.pd_s2)
                        nxt_s.phase = scc_pkg::ST_SLEEP;
                scc_pkg::ST_SLEEP:
                    if (!s_ff.pd_s2)
                    begin
                        nxt_s.phase = scc_pkg::ST_WAKE;
                        nxt_s.dly = 24'(scc_pkg::WAKE_CYCLES - 1);
                    end
                scc_pkg::ST_WAKE:
                    if (s_ff.dly == 24'h000000)
                        nxt_s.phase = scc_pkg::ST_RUN;
                    else
                        nxt_s.dly = s_ff.dly - 24'h000001;
                default:
                    nxt_s.phase = scc_pkg::ST_BOOT;
            endcase

            if (s_ff.pce)
            begin
                if (s_ff.pce_cnt == 3'h0)
                    nxt_s.pce = 1'b0;
                else
                    nxt_s.pce_cnt = s_ff.pce_cnt - 3'h1;
            end

            if (s_ff.bvalid && s_axi_bready)
                nxt_s.bvalid = 1'b0;
            if (wr_take)
            begin
                nxt_s.bvalid = 1'b1;
                nxt_s.bresp = (wr_hit == 3'h0) ? scc_pkg::RESP_SLVERR
                                               : scc_pkg::RESP_OKAY;
                if (s_axi_wstrb[0] && wr_hit == 3'h1)
                begin
                    // unlock only with other bits zero
                    if (wd == scc_pkg::PCE_UNLOCK)
                    begin
                        if (!s_ff.pce)
                        begin
                            nxt_s.pce = 1'b1;
                            nxt_s.pce_cnt = scc_pkg::PCE_WINDOW - 3'h1;
                        end
                    end
                    else if (!wd[scc_pkg::PCE_BIT] && s_ff.pce)
                    begin
                        nxt_s.pce = 1'b0;
                        if (wd[3:0] <= scc_pkg::SEL_MAX)
                        begin
                            nxt_s.sel = wd[3:0];
                            nxt_s.pend = 1'b1;
                        end
                    end
                end
                else if (s_axi_wstrb[0] && wr_hit == 3'h2)
                    nxt_s.trim = wd;
                else if (s_axi_wstrb[0] && wr_hit == 3'h3)
                    nxt_s.tmr_ext = wd[scc_pkg::CTRL_TMR_EXT_BIT];
            end

            if (s_ff.rvalid && s_axi_rready)
                nxt_s.rvalid = 1'b0;
            if (rd_take)
            begin
                nxt_s.rvalid = 1'b1;
                nxt_s.rresp = scc_pkg::RESP_OKAY;
                case (reg_hit(s_axi_araddr))
                    3'h1:
                        nxt_s.rdata = {24'h000000, s_ff.pce, 3'h0, s_ff.sel};
                    3'h2:
                        nxt_s.rdata = {24'h000000, s_ff.trim};
                    3'h3:
                        nxt_s.rdata = {31'h00000000, s_ff.tmr_ext};
                    3'h4:
                        nxt_s.rdata = {21'h000000, core_running,
                                       timer_osc_enable, ext_clock_selected,
                                       s_ff.fuse_lat};
                    default:
                    begin
                        nxt_s.rdata = 32'h0000_0000;
                        nxt_s.rresp = scc_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (ce)
            s_ff <= nxt_s;
    end

    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rresp = s_ff.rresp;
    assign s_axi_rdata = s_ff.rdata;

    assign clock_output_pin_oe = s_ff.fuse_lat.clock_output_fuse;
    assign clock_output_pin = s_ff.clk_div && s_ff.fuse_lat.clock_output_fuse;
    assign domain_en = {4{s_ff.tick}};
    // range bit and fine bits go straight to the cell
    assign rc_oscillator_trim_out = s_ff.trim;
    assign ext_clock_selected = s_ff.fuse_lat.src == scc_pkg::EXT_CLK_CODE;
    // timer oscillator needs the RC clock
    assign timer_osc_enable = s_ff.fuse_lat.src == scc_pkg::RC_CLK_CODE;
    assign timer_external_clock_select = s_ff.tmr_ext;
    assign core_running = s_ff.phase == scc_pkg::ST_RUN;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !ce);

    a_pce_unlock_only: assert property (
        $rose(s_ff.pce) |-> $past(wr_take && wr_hit == 3'h1 &&
            s_axi_wstrb[0] && wd == scc_pkg::PCE_UNLOCK))
        else $error("change enable set without unlock write");

    a_pce_window_end: assert property (
        $rose(s_ff.pce) |-> ##4 !s_ff.pce)
        else $error("change enable outlived its window");

    a_sel_needs_pce: assert property (
        $changed(s_ff.sel) |-> $past(s_ff.pce) && !s_ff.pce)
        else $error("select changed without unlock");

    a_sel_not_reserved: assert property (
        s_ff.sel <= scc_pkg::SEL_MAX && s_ff.act_sel <= scc_pkg::SEL_MAX)
        else $error("reserved division factor active");

    // Reset toggles the pin every cycle, so the first edge after it is skipped
    a_toggle_boundary: assert property (
        $changed(s_ff.clk_div) && $past(aresetn) |->
            $past(s_ff.half_cnt) == half_limit($past(s_ff.act_sel)))
        else $error("divided clock toggled mid period");

    a_factor_at_rise: assert property (
        $changed(s_ff.act_sel) |-> s_ff.clk_div && !$past(s_ff.clk_div))
        else $error("factor switched away from a rising edge");

    a_tick_on_rise: assert property (
        s_ff.tick |-> s_ff.clk_div && !$past(s_ff.clk_div) &&
            domain_en.core && domain_en.io)
        else $error("domain tick not on divided rising edge");

    a_pin_follows: assert property (
        s_ff.fuse_lat.clock_output_fuse |-> clock_output_pin_oe &&
            clock_output_pin == s_ff.clk_div)
        else $error("clock output pin not driven");

    a_reset_select: assert property (
        $rose(aresetn) |-> s_ff.sel == (s_ff.fuse_lat.div8 ?
            scc_pkg::SEL_RST_DIV8 : scc_pkg::SEL_RST_PLAIN))
        else $error("wrong select after reset");

    a_trim_reload: assert property (
        $rose(aresetn) |-> rc_oscillator_trim_out == s_ff.trim_s2)
        else $error("factory trim not loaded at reset");

    // Own disable: this one must watch the pin while reset is held
    a_pin_in_reset: assert property (disable iff (!ce)
        !aresetn && $past(!aresetn) && $past(ce) &&
            s_ff.fuse_lat.clock_output_fuse && $past(s_ff.fuse_lat.clock_output_fuse)
        |-> $changed(clock_output_pin))
        else $error("clock output pin idle during reset");

    a_select_clears: assert property (
        s_ff.pce && wr_take && wr_hit == 3'h1 && s_axi_wstrb[0] &&
            !wd[scc_pkg::PCE_BIT] |=> !s_ff.pce)
        else $error("select write left change enable set");

    a_wake_delay: assert property (
        s_ff.phase == scc_pkg::ST_WAKE &&
            $past(s_ff.phase) == scc_pkg::ST_SLEEP
        |-> !core_running ##12 core_running)
        else $error("wake delay not six master cycles");

    a_bresp_hold: assert property (
        s_ff.bvalid && !s_axi_bready |=> s_ff.bvalid && $stable(s_ff.bresp))
        else $error("write response dropped");

    c_prescale_change: cover property (
        $rose(s_ff.pce) ##[1:4] $changed(s_ff.sel));
    c_reserved_write: cover property (
        s_ff.pce && wr_take && wr_hit == 3'h1 && wd[3:0] > scc_pkg::SEL_MAX);
    c_wake: cover property (
        s_ff.phase == scc_pkg::ST_SLEEP ##1 s_ff.phase == scc_pkg::ST_WAKE);
    c_status_read: cover property (rd_take && reg_hit(s_axi_araddr) == 3'h4);

endmodule : scc_top

/* File: tb/scc_clk_watch.sv */
/*
 Downstream clocked circuit fed by the clock output pin: measures the
 length of each high and low run of the divided clock in aclk cycles.
 Assumes the pin is a register that changes only at rising aclk edges.
*/
`timescale 1ns/100ps
module scc_clk_watch (
    input wire logic aclk,
    input wire logic clr,
    input wire logic clk_in,
    output int hi_len,
    output int lo_len,
    output int min_run
);
    int run;
    logic last;
    logic armed;

    always @(posedge aclk)
    begin
        last <= clk_in;
        if (clr)
        begin
            armed <= 1'b0;
            min_run <= 100000;
            run <= 1;
        end
        else if (clk_in != last)
        begin
            // A run cut short by clr is not a real period
            if (armed)
            begin
                if (last)
                    hi_len <= run;
                else
                    lo_len <= run;
                if (run < min_run)
                    min_run <= run;
            end
            armed <= 1'b1;
            run <= 1;
        end
        else
            run <= run + 1;
    end
endmodule : scc_clk_watch

/* File: tb/tb_top.sv */
/*
 Self-checking bench of the system clock control block over AXI4-Lite.
 Assumes fuses first select the external clock, shortest start-up, clock
 output and divide-by-eight; a mid-run reset then switches them to the
 RC clock and short start-up; small start-up delay parameters.
*/
`timescale 1ns/100ps
module tb_top;
    localparam logic [11:0] A_PRE = {scc_pkg::PRESCALE_IDX, 2'b00};
    localparam logic [11:0] A_TRIM = {scc_pkg::TRIM_IDX, 2'b00};
    localparam logic [11:0] A_CTRL = {scc_pkg::CTRL_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {scc_pkg::STATUS_IDX, 2'b00};
    logic aclk = 0, aresetn = 0, power_down = 0, clr = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pin, pin_oe;
    logic ext_sel, tmr_osc, tmr_ext, running;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] trim_out;
    logic [31:0] rd;
    scc_pkg::scc_fuse_type fuses = '{4'h0, 2'h0, 1'b1, 1'b1};
    logic [7:0] trim_in = 8'h5A;
    scc_pkg::scc_domain_type dom;
    int hi_len, lo_len, min_run, err_total = 0, cmp_count = 0;

    // Source clock has a fixed period
    always #5 aclk = ~aclk;

    scc_top #(.SHORT_DELAY_CYCLES(24'h14), .LONG_DELAY_CYCLES(24'h28)) uut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fuses(fuses), .factory_trim(trim_in), .power_down(power_down),
        .clock_output_pin(pin), .clock_output_pin_oe(pin_oe),
        .domain_en(dom), .rc_oscillator_trim_out(trim_out),
        .ext_clock_selected(ext_sel), .timer_osc_enable(tmr_osc),
        .timer_external_clock_select(tmr_ext), .core_running(running)
    );

    scc_clk_watch watch (.aclk(aclk), .clr(clr), .clk_in(pin),
        .hi_len(hi_len), .lo_len(lo_len), .min_run(min_run));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end while ((awready & wready) !== 1'b1 && n < 99);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 99);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 99);
        arvalid <= 1'b0;
        do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 99);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rdr

    task automatic t_reset;
        int n;
        n = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        do begin @(posedge aclk); n++; end while (running !== 1'b1 && n < 99);
        chk(32'(n >= 28 && n <= 32), 32'h1);
        chk(32'(pin_oe), 32'h1);
        chk(32'(ext_sel), 32'h1);
        rdr(A_PRE);
        chk(rd, 32'h3);
        rdr(A_TRIM);
        chk(rd, 32'h5A);
        rdr(A_STAT);
        chk(rd, 32'h503);
        $display("reset test done");
    endtask : t_reset

    task automatic t_unlock;
        wr(A_PRE, 32'h2);
        wr(A_PRE, 32'h81);
        wr(A_PRE, 32'h2);
        rdr(A_PRE);
        chk(rd, 32'h3);
        wr(A_PRE, 32'h80);
        rdr(A_PRE);
        chk(rd, 32'h83);
        repeat (4) @(posedge aclk);
        rdr(A_PRE);
        chk(rd, 32'h3);
        wr(A_PRE, 32'h2);
        rdr(A_PRE);
        chk(rd, 32'h3);
        $display("unlock test done");
    endtask : t_unlock

    task automatic t_codes;
        int old;
        int n;
        old = 8;
        for (int c = 0; c <= 9; c++)
        begin
            wr(A_PRE, 32'h80);
            wr(A_PRE, 32'(c));
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            rdr(A_PRE);
            chk(rd, (c > 8) ? 32'h8 : 32'(c));
            if (c > 8)
                break;
            repeat (2 * old + 4 * (1 << c) + 8) @(posedge aclk);
            chk(32'(hi_len), 32'(1 << c));
            chk(32'(lo_len), 32'(1 << c));
            chk(32'(min_run >= ((old < (1 << c)) ? old : (1 << c))), 1);
            old = 1 << c;
        end
        n = 0;
        do begin @(posedge aclk); n++; end while (dom == 4'h0 && n < 600);
        chk(32'(dom), 32'hF);
        $display("prescaler test done");
    endtask : t_codes

    task automatic t_regs;
        int n;
        // No memory write runs while the trim moves
        wr(A_TRIM, 32'h7F);
        rdr(A_TRIM);
        chk(rd, 32'h7F);
        wr(A_TRIM, 32'h80);
        chk(32'(trim_out), 32'h80);
        wr(A_CTRL, 32'h1);
        chk(32'(tmr_ext), 32'h1);
        chk(32'(tmr_osc), 32'h0);
        wr(12'hFFC, 32'h1);
        chk(32'(resp), 32'(scc_pkg::RESP_SLVERR));
        power_down <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(running), 32'h0);
        power_down <= 1'b0;
        n = 0;
        do begin @(posedge aclk); n++; end while (running !== 1'b1 && n < 99);
        chk(32'(n >= 12 && n <= 16), 32'h1);
        $display("register and wake test done");
    endtask : t_regs

    task automatic t_rerun;
        int n;
        n = 0;
        // Mid-run reset with the RC clock, short start-up, no output fuse
        fuses <= '{scc_pkg::RC_CLK_CODE, 2'h1, 1'b0, 1'b0};
        trim_in <= 8'hA5;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        do begin @(posedge aclk); n++; end while (running !== 1'b1 && n < 99);
        chk(32'(n >= 48 && n <= 52), 32'h1);
        chk(32'({pin_oe, pin}), 32'h0);
        chk(32'({ext_sel, tmr_osc}), 32'h1);
        rdr(A_PRE);
        chk(rd, 32'h0);
        rdr(A_TRIM);
        chk(rd, 32'hA5);
        chk(32'(resp), 32'(scc_pkg::RESP_OKAY));
        rdr(A_STAT);
        chk(rd, 32'h624);
        $display("mid-run reset test done");
    endtask : t_rerun

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    initial
    begin
        #(60000 * 10);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end

    initial
    begin
        t_reset();
        t_unlock();
        t_codes();
        t_regs();
        t_rerun();
        test_done();
    end
endmodule : tb_top
